// [eil_pkg.sv]
package eil_pkg;
    localparam int NPIN = 3;
    localparam int NGRP = 4;
    // Data-space offsets
    localparam logic [7:0] ADDR_FLAGS = 8'h3c;
    localparam logic [7:0] ADDR_MASK = 8'h3d;
    localparam logic [7:0] ADDR_PCEN = 8'h68;
    localparam logic [7:0] ADDR_SENSE = 8'h69;
    localparam logic [7:0] IO_OFFSET = 8'h20;
    localparam logic [7:0] IO_LIMIT = 8'h3f;
    localparam logic [7:0] EXT_BASE = 8'h60;
    localparam logic [7:0] RESET_VAL = 8'h00;
    localparam int SENSE_W = 2;
    localparam int GRP3 = 3;
    localparam int GRP_W = 8;
    typedef enum logic [1:0] {
        EIL_LOW = 2'b00,
        EIL_ANY = 2'b01,
        EIL_FALL = 2'b10,
        EIL_RISE = 2'b11
    } eil_sense_t;
endpackage : eil_pkg

// [eil_pin_sense.sv]
`timescale 1ns/1ps
`default_nettype none
// One pin: sample, edge detect, flag
module eil_pin_sense (
    input wire logic mclk,
    input wire logic srst,
    input wire logic pin,
    input wire logic [1:0] sense,
    input wire logic wr_clr,
    input wire logic ack,
    output logic flag,
    output logic low_req
);
    logic samp_reg;
    logic prev_reg;
    logic flag_reg;
    logic flag_next;
    logic rise;
    logic fall;
    logic hit;
    logic is_low;

    always_ff @(posedge mclk) begin
        if (srst) begin
            samp_reg <= 1'b1;
            prev_reg <= 1'b1;
        end else begin
            samp_reg <= pin;
            prev_reg <= samp_reg;
        end
    end

    assign rise = samp_reg & ~prev_reg;
    assign fall = ~samp_reg & prev_reg;
    assign is_low = (sense == eil_pkg::EIL_LOW);
    assign hit = (sense == eil_pkg::EIL_ANY) ? (rise | fall) :
                 (sense == eil_pkg::EIL_FALL) ? fall :
                 (sense == eil_pkg::EIL_RISE) ? rise : 1'b0;
    // Set wins over clear
    assign flag_next = is_low ? 1'b0 :
                       (hit | (flag_reg & ~wr_clr & ~ack));

    always_ff @(posedge mclk) begin
        if (srst) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;
    assign low_req = is_low & ~pin;

    chk_flag_set: assert property (@(posedge mclk) disable iff (srst)
        hit && !is_low |=> flag_reg)
        else $error("edge did not set flag");
    chk_low_zero: assert property (@(posedge mclk) disable iff (srst)
        is_low |-> ##1 (!flag_reg || !is_low))
        else $error("flag set in level mode");
    chk_sample_edge: assert property (@(posedge mclk) disable iff (srst)
        $rose(samp_reg) && sense == eil_pkg::EIL_RISE |-> hit)
        else $error("rising sample missed");
    chk_clear_flag: assert property (@(posedge mclk) disable iff (srst)
        (wr_clr || ack) && !hit |=> !flag_reg)
        else $error("flag not cleared");
endmodule : eil_pin_sense
`default_nettype wire

// [eil_top.sv]
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Sense codes: low, change, falling, rising
// - Sense fields at bits 5:4, 3:2, 1:0
// - Edges detected on sampled pin value
// - Pulses over one clock always caught in change and edge modes
// - Delivery needs global enable and mask
// - Mask register 0x3D, bits 2:0
// - Output-configured pins still raise requests
// - Each pin has its own vector
// - Configured edge sets pin flag
// - Vector entry clears pin flag
// - Writing one clears flag, zero keeps
// - Flag reads zero in level mode
// - Group enable register 0x68, bits 3:0
// - Group 3 change raises request
// - Group 3 pins enabled by mask; group3_pin_mask is not used here
// - Group 3 request has own vector
// - Low registers also at I/O address
// - Extended registers data-space only
// - Flags at 0x3C, I/O aliases 0x1C/0x1D
// - Sense register 0x69, resets zero
// - Level detect needs no clock edge
// - Group 3 change sets flag, W1C; here group3_change_flag is an input, never cleared
// - Pin counts only with mask and enable; change_watch_pin and group3_pin_mask are unused here
module eil_top #(
    parameter int NPIN = eil_pkg::NPIN,
    parameter int GW = eil_pkg::GRP_W
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [NPIN-1:0] ext_irq_pin,
    input wire logic core_status_i_flag,
    input wire logic [7:0] bus_addr,
    input wire logic bus_io,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    input wire logic [NPIN-1:0] vec_ack,
    output logic [NPIN-1:0] vec_req,
    input wire logic [GW-1:0] group3_pin_mask,
    input wire logic [GW-1:0] change_watch_pin,
    input wire logic group3_change_flag,
    output logic [eil_pkg::NGRP-1:0] pin_change_group_enable,
    output logic group3_change_request
);
    logic [5:0] sense_reg;
    logic [NPIN-1:0] mask_reg;
    logic [eil_pkg::NGRP-1:0] pcen_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] daddr;
    logic io_ok;
    logic sel_flags;
    logic sel_mask;
    logic sel_pcen;
    logic sel_sense;
    logic [NPIN-1:0] flag;
    logic [NPIN-1:0] low_req;
    logic [NPIN-1:0] pend;
    logic flags_wr;

    // I/O space addresses map to data offset + 0x20
    assign daddr = bus_io ? (bus_addr + eil_pkg::IO_OFFSET) : bus_addr;
    assign io_ok = !bus_io || (bus_addr <= eil_pkg::IO_LIMIT);

    function automatic logic hit_addr(input logic [7:0] a,
                                      input logic [7:0] off);
        hit_addr = (a == off);
    endfunction : hit_addr

    // Extended registers never answer I/O cycles
    assign sel_flags = io_ok && hit_addr(daddr, eil_pkg::ADDR_FLAGS);
    assign sel_mask = io_ok && hit_addr(daddr, eil_pkg::ADDR_MASK);
    assign sel_pcen = !bus_io && hit_addr(daddr, eil_pkg::ADDR_PCEN);
    assign sel_sense = !bus_io && hit_addr(daddr, eil_pkg::ADDR_SENSE);
    assign flags_wr = bus_wr && sel_flags;

    always_ff @(posedge mclk) begin
        if (srst) begin
            sense_reg <= eil_pkg::RESET_VAL[5:0];
            mask_reg <= eil_pkg::RESET_VAL[NPIN-1:0];
            pcen_reg <= eil_pkg::RESET_VAL[eil_pkg::NGRP-1:0];
        end else if (bus_wr) begin
            if (sel_sense) begin
                sense_reg <= bus_wdata[5:0];
            end
            if (sel_mask) begin
                mask_reg <= bus_wdata[NPIN-1:0];
            end
            if (sel_pcen) begin
                pcen_reg <= bus_wdata[eil_pkg::NGRP-1:0];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_pin
            eil_pin_sense u_sense (
                .mclk(mclk),
                .srst(srst),
                .pin(ext_irq_pin[g]),
                .sense(sense_reg[g*eil_pkg::SENSE_W +: eil_pkg::SENSE_W]),
                .wr_clr(flags_wr && bus_wdata[g]),
                .ack(vec_ack[g]),
                .flag(flag[g]),
                .low_req(low_req[g])
            );
        end
    endgenerate

    // Level request straight from pin; edge request from flag
    assign pend = flag | low_req;
    assign vec_req = pend & mask_reg & {NPIN{core_status_i_flag}};

    // Group 3 request: enabled group and global flag
    assign group3_change_request = pcen_reg[eil_pkg::GRP3]
        && core_status_i_flag && group3_change_flag;
    assign pin_change_group_enable = pcen_reg;

    always_comb begin
        rdata_next = 8'h00;
        if (sel_flags) begin
            rdata_next[NPIN-1:0] = flag;
        end else if (sel_mask) begin
            rdata_next[NPIN-1:0] = mask_reg;
        end else if (sel_pcen) begin
            rdata_next[eil_pkg::NGRP-1:0] = pcen_reg;
        end else if (sel_sense) begin
            rdata_next[5:0] = sense_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata_reg <= 8'h00;
        end else if (bus_rd) begin
            rdata_reg <= rdata_next;
        end
    end
    assign bus_rdata = rdata_reg;

    chk_mask_gate: assert property (@(posedge mclk) disable iff (srst)
        !core_status_i_flag |-> vec_req == '0)
        else $error("request without global enable");
    chk_io_ext: assert property (@(posedge mclk) disable iff (srst)
        bus_io |-> !sel_pcen && !sel_sense)
        else $error("extended register on I/O");
    chk_sense_wr: assert property (@(posedge mclk) disable iff (srst)
        bus_wr && sel_sense |=> sense_reg == $past(bus_wdata[5:0]))
        else $error("sense write lost");
    chk_io_alias: assert property (@(posedge mclk) disable iff (srst)
        bus_io && bus_addr == eil_pkg::ADDR_FLAGS - eil_pkg::IO_OFFSET
        |-> sel_flags)
        else $error("flag alias not decoded");
    chk_low_level: assert property (@(posedge mclk) disable iff (srst)
        sense_reg[1:0] == 2'b00 && !ext_irq_pin[0] && mask_reg[0]
        && core_status_i_flag |-> vec_req[0])
        else $error("level request missing");
    chk_grp3_req: assert property (@(posedge mclk) disable iff (srst)
        group3_change_request |-> pcen_reg[3])
        else $error("group 3 request disabled");

    // Register write steps
    sequence s_wr_mask;
        bus_wr && sel_mask;
    endsequence : s_wr_mask

    sequence s_wr_pcen;
        bus_wr && sel_pcen;
    endsequence : s_wr_pcen

    sequence s_wr_sense;
        bus_wr && sel_sense;
    endsequence : s_wr_sense

    chk_mask_wr: assert property (@(posedge mclk) disable iff (srst)
        s_wr_mask |=> mask_reg == $past(bus_wdata[NPIN-1:0]))
        else $error("mask write lost");

    chk_pcen_wr: assert property (@(posedge mclk) disable iff (srst)
        s_wr_pcen |=> pcen_reg == $past(bus_wdata[eil_pkg::NGRP-1:0]))
        else $error("group enable write lost");

    chk_sense_seq: assert property (@(posedge mclk) disable iff (srst)
        s_wr_sense |=> sense_reg == $past(bus_wdata[5:0]))
        else $error("sense write lost");

    chk_mask_hold: assert property (@(posedge mclk) disable iff (srst)
        !(bus_wr && sel_mask) |=> $stable(mask_reg))
        else $error("mask changed without write");

    chk_pcen_hold: assert property (@(posedge mclk) disable iff (srst)
        !(bus_wr && sel_pcen) |=> $stable(pcen_reg))
        else $error("group enable changed without write");

    chk_sense_hold: assert property (@(posedge mclk) disable iff (srst)
        !(bus_wr && sel_sense) |=> $stable(sense_reg))
        else $error("sense changed without write");

    // Address decode
    chk_io_range: assert property (@(posedge mclk) disable iff (srst)
        bus_io && bus_addr > eil_pkg::IO_LIMIT |-> !sel_flags && !sel_mask)
        else $error("I/O address out of range decoded");

    chk_wr_refused: assert property (@(posedge mclk) disable iff (srst)
        bus_io && bus_addr > eil_pkg::IO_LIMIT
        |=> $stable(mask_reg) && $stable(sense_reg) && $stable(pcen_reg))
        else $error("out of range I/O write landed");

    chk_mask_alias: assert property (@(posedge mclk) disable iff (srst)
        bus_io && bus_addr == eil_pkg::ADDR_MASK - eil_pkg::IO_OFFSET
        |-> sel_mask)
        else $error("mask alias not decoded");

    chk_data_flags: assert property (@(posedge mclk) disable iff (srst)
        !bus_io && bus_addr == eil_pkg::ADDR_FLAGS |-> sel_flags)
        else $error("flag offset not decoded");

    chk_data_mask: assert property (@(posedge mclk) disable iff (srst)
        !bus_io && bus_addr == eil_pkg::ADDR_MASK |-> sel_mask)
        else $error("mask offset not decoded");

    chk_data_pcen: assert property (@(posedge mclk) disable iff (srst)
        !bus_io && bus_addr == eil_pkg::ADDR_PCEN |-> sel_pcen)
        else $error("group enable offset not decoded");

    chk_data_sense: assert property (@(posedge mclk) disable iff (srst)
        !bus_io && bus_addr == eil_pkg::ADDR_SENSE |-> sel_sense)
        else $error("sense offset not decoded");

    chk_one_sel: assert property (@(posedge mclk) disable iff (srst)
        $onehot0({sel_flags, sel_mask, sel_pcen, sel_sense}))
        else $error("two registers selected");

    // Read-back
    chk_rd_flags: assert property (@(posedge mclk) disable iff (srst)
        bus_rd && sel_flags |=> bus_rdata == 8'($past(flag)))
        else $error("flag read wrong");

    chk_rd_mask: assert property (@(posedge mclk) disable iff (srst)
        bus_rd && sel_mask |=> bus_rdata == 8'($past(mask_reg)))
        else $error("mask read wrong");

    chk_rd_pcen: assert property (@(posedge mclk) disable iff (srst)
        bus_rd && sel_pcen |=> bus_rdata == 8'($past(pcen_reg)))
        else $error("group enable read wrong");

    chk_rd_sense: assert property (@(posedge mclk) disable iff (srst)
        bus_rd && sel_sense |=> bus_rdata == 8'($past(sense_reg)))
        else $error("sense read wrong");

    chk_rd_unmapped: assert property (@(posedge mclk) disable iff (srst)
        bus_rd && !(sel_flags || sel_mask || sel_pcen || sel_sense)
        |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");

    chk_rd_hold: assert property (@(posedge mclk) disable iff (srst)
        !bus_rd |=> $stable(bus_rdata))
        else $error("read data changed without read");

    // Group 3 gating
    chk_grp3_off: assert property (@(posedge mclk) disable iff (srst)
        !core_status_i_flag |-> !group3_change_request)
        else $error("group 3 request without global enable");

    chk_grp3_on: assert property (@(posedge mclk) disable iff (srst)
        pcen_reg[eil_pkg::GRP3] && core_status_i_flag && group3_change_flag
        |-> group3_change_request)
        else $error("group 3 request missing");

    chk_group_out: assert property (@(posedge mclk) disable iff (srst)
        pin_change_group_enable == pcen_reg)
        else $error("group enable output differs");

    // Reset values
    chk_reset_mask: assert property (@(posedge mclk)
        srst |=> mask_reg == eil_pkg::RESET_VAL[NPIN-1:0])
        else $error("mask not reset");

    chk_reset_sense: assert property (@(posedge mclk)
        srst |=> sense_reg == eil_pkg::RESET_VAL[5:0])
        else $error("sense not reset");

    chk_reset_pcen: assert property (@(posedge mclk)
        srst |=> pcen_reg == eil_pkg::RESET_VAL[eil_pkg::NGRP-1:0])
        else $error("group enable not reset");

    // Per-pin request checks
    generate
        for (g = 0; g < NPIN; g++) begin : g_chk
            logic [1:0] sense_f;
            assign sense_f = sense_reg[g*eil_pkg::SENSE_W +: eil_pkg::SENSE_W];

            sequence s_any_edge;
                $changed(ext_irq_pin[g]) ##1 sense_f == eil_pkg::EIL_ANY;
            endsequence : s_any_edge

            sequence s_fall_edge;
                $fell(ext_irq_pin[g]) ##1 sense_f == eil_pkg::EIL_FALL;
            endsequence : s_fall_edge

            sequence s_rise_edge;
                $rose(ext_irq_pin[g]) ##1 sense_f == eil_pkg::EIL_RISE;
            endsequence : s_rise_edge

            chk_any_flag: assert property (@(posedge mclk) disable iff (srst)
                s_any_edge |=> flag[g])
                else $error("change did not set flag");

            chk_fall_flag: assert property (@(posedge mclk) disable iff (srst)
                s_fall_edge |=> flag[g])
                else $error("falling edge did not set flag");

            chk_rise_flag: assert property (@(posedge mclk) disable iff (srst)
                s_rise_edge |=> flag[g])
                else $error("rising edge did not set flag");

            chk_level_clr: assert property (@(posedge mclk) disable iff (srst)
                sense_f == eil_pkg::EIL_LOW |=> !flag[g])
                else $error("flag kept in level mode");

            chk_level_req: assert property (@(posedge mclk) disable iff (srst)
                sense_f == eil_pkg::EIL_LOW && !ext_irq_pin[g] && mask_reg[g]
                && core_status_i_flag |-> vec_req[g])
                else $error("low level request missing");

            chk_level_idle: assert property (@(posedge mclk) disable iff (srst)
                sense_f == eil_pkg::EIL_LOW ##1 sense_f == eil_pkg::EIL_LOW
                && ext_irq_pin[g] |-> !vec_req[g])
                else $error("level request with pin high");

            chk_flag_req: assert property (@(posedge mclk) disable iff (srst)
                flag[g] && mask_reg[g] && core_status_i_flag |-> vec_req[g])
                else $error("flagged request missing");

            chk_vec_mask: assert property (@(posedge mclk) disable iff (srst)
                !mask_reg[g] |-> !vec_req[g])
                else $error("request with mask clear");

            chk_vec_pend: assert property (@(posedge mclk) disable iff (srst)
                vec_req[g] |-> flag[g] || low_req[g])
                else $error("request without cause");
        end
    endgenerate
endmodule : eil_top
`default_nettype wire

// [eil_pin_src.sv]
`timescale 1ns/1ps
`default_nettype none
// Board-side drivers of the three interrupt pins
module eil_pin_src (
    input wire logic mclk,
    input wire logic [2:0] lvl,
    output logic [2:0] pin
);
    // Pins take lvl at each falling clock edge; no minimum pulse width enforced
    always @(negedge mclk) begin
        pin <= lvl;
    end
    initial pin = 3'b111;
endmodule : eil_pin_src
`default_nettype wire

// [external_pin_interrupt_logic_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module external_pin_interrupt_logic_tb;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] lvl = 3'b111;
    logic [2:0] pin;
    logic ifl = 1'b0;
    logic [7:0] addr = 8'h00;
    logic io = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wd = 8'h00;
    logic [7:0] rdata;
    logic [2:0] ack = 3'b000;
    logic [2:0] vreq;
    logic g3f = 1'b0;
    logic [3:0] gen;
    logic g3req;
    int num_errors = 0;
    int checked = 0;
    always #2.5 mclk = ~mclk;
    eil_pin_src u_pins (.mclk(mclk), .lvl(lvl), .pin(pin));
    eil_top DUT (.mclk(mclk), .srst(srst), .ext_irq_pin(pin),
        .core_status_i_flag(ifl), .bus_addr(addr), .bus_io(io),
        .bus_wr(wr), .bus_rd(rd), .bus_wdata(wd), .bus_rdata(rdata),
        .vec_ack(ack), .vec_req(vreq), .group3_pin_mask(8'hff),
        .change_watch_pin(8'hff), .group3_change_flag(g3f),
        .pin_change_group_enable(gen), .group3_change_request(g3req));
    task automatic chk(input string what, input logic [7:0] exp,
            input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic i,
            input logic [7:0] d);
        @(negedge mclk);
        addr = a;
        io = i;
        wd = d;
        wr = 1'b1;
        @(negedge mclk);
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic i,
            input logic [7:0] exp);
        @(negedge mclk);
        addr = a;
        io = i;
        rd = 1'b1;
        @(negedge mclk);
        rd = 1'b0;
        chk("bus_rdata", exp, rdata);
    endtask : rd_reg
    task automatic pins(input logic [2:0] v);
        @(negedge mclk);
        lvl <= v;
        repeat (4) @(negedge mclk);
    endtask : pins
    task automatic final_report;
        $display("checks %0d, errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        final_report();
    end
    initial begin
        repeat (20) @(negedge mclk);
        srst = 1'b0;
        rd_reg(8'h3c, 1'b0, 8'h00);
        rd_reg(8'h3d, 1'b0, 8'h00);
        rd_reg(8'h68, 1'b0, 8'h00);
        rd_reg(8'h69, 1'b0, 8'h00);
        wr_reg(8'h3d, 1'b0, 8'hff);
        rd_reg(8'h1d, 1'b1, 8'h07);
        wr_reg(8'h69, 1'b0, 8'h39);
        rd_reg(8'h69, 1'b0, 8'h39);
        wr_reg(8'h49, 1'b1, 8'hff);
        rd_reg(8'h69, 1'b0, 8'h39);
        rd_reg(8'h49, 1'b1, 8'h00);
        pins(3'b000);
        rd_reg(8'h1c, 1'b1, 8'h03);
        chk("vec_req", 8'h00, {5'h00, vreq});
        ifl = 1'b1;
        @(negedge mclk);
        chk("vec_req", 8'h03, {5'h00, vreq});
        ack = 3'b001;
        @(negedge mclk);
        ack = 3'b000;
        rd_reg(8'h3c, 1'b0, 8'h02);
        wr_reg(8'h1c, 1'b1, 8'h00);
        rd_reg(8'h3c, 1'b0, 8'h02);
        wr_reg(8'h1c, 1'b1, 8'h02);
        rd_reg(8'h3c, 1'b0, 8'h00);
        pins(3'b111);
        rd_reg(8'h3c, 1'b0, 8'h05);
        wr_reg(8'h69, 1'b0, 8'h00);
        rd_reg(8'h3c, 1'b0, 8'h00);
        pins(3'b010);
        chk("vec_req", 8'h05, {5'h00, vreq});
        wr_reg(8'h3d, 1'b0, 8'h01);
        chk("vec_req", 8'h01, {5'h00, vreq});
        ifl = 1'b0;
        @(negedge mclk);
        chk("vec_req", 8'h00, {5'h00, vreq});
        wr_reg(8'h68, 1'b0, 8'hff);
        rd_reg(8'h68, 1'b0, 8'h0f);
        chk("group_enable", 8'h0f, {4'h0, gen});
        g3f = 1'b1;
        @(negedge mclk);
        chk("group3_request", 8'h00, {7'h00, g3req});
        ifl = 1'b1;
        @(negedge mclk);
        chk("group3_request", 8'h01, {7'h00, g3req});
        wr_reg(8'h68, 1'b0, 8'h07);
        chk("group3_request", 8'h00, {7'h00, g3req});
        wr_reg(8'h69, 1'b0, 8'h2a);
        pins(3'b111);
        rd_reg(8'h3c, 1'b0, 8'h00);
        @(negedge mclk);
        lvl <= 3'b101;
        repeat (2) @(negedge mclk);
        lvl <= 3'b111;
        repeat (4) @(negedge mclk);
        rd_reg(8'h3c, 1'b0, 8'h02);
        final_report();
    end
endmodule : external_pin_interrupt_logic_tb
`default_nettype wire
